/* inc/sacc_defines.svh */
// How it works
// - input count select 0 = four inputs, 1 = inputs one-three, 2 = inputs one and three
// - per-channel sample method bit, 0 double sampling, 1 single sample-and-hold
// - each channel has its own input polarity bit
// - double sampling takes reference pulse then data pulse, difference is pixel value
// - single sample uses only the data pulse, difference against the clamp voltage
// - single-sample reference enable uses internal clamp voltage instead of ground pin
// - clamp mode 0 pixel, 1 line, 2 unclamped internal, 3 unclamped ground pin
// - pixel clamp fires the group clamp pulse once per pixel, window ignored
// - line clamp uses group reference pulse only inside the dummy-pixel window
// - line clamp is refused for channels in single sample mode
// - clamp level 0 fixed 2.2 V, 1 reference DAC, 2 reference pin voltage
// - DAC level 2 = 0.5 V, 3 = 1.1 V, 0 = 1.5 V, 1 = 2.0 V, 0 at reset
// - reference pin drives DAC level out or accepts an external reference
// - window start and end are clock counts from line strobe falling edge
// - group A serves inputs one and two, group B inputs three and four
// - each pixel clamp pulse starts at its group reference pulse rising edge
// - clamp pulse ends at half the reference pulse width or a programmed count
// - clamp end manual select 0 automatic, 1 register-defined end
// - window stays high after reset until the control word window enable bit is set
`ifndef SACC_DEFINES_SVH
`define SACC_DEFINES_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SACC_ADDR_W 4
`define SACC_OFS_CTRL 4'h0
`define SACC_OFS_CHCFG 4'h1
`define SACC_OFS_WSTART 4'h2
`define SACC_OFS_WEND 4'h3
`define SACC_OFS_CLPEND 4'h4
`define SACC_OFS_STATUS 4'h5

// ------------------------------------------------------------
// control word fields
// ------------------------------------------------------------
`define SACC_CTRL_COUNT_LSB 0
`define SACC_CTRL_DAC_LSB 4
`define SACC_CTRL_MANUAL_BIT 8
`define SACC_CTRL_WINEN_BIT 9

// ------------------------------------------------------------
// per-channel byte fields
// ------------------------------------------------------------
`define SACC_CH_SH_BIT 0
`define SACC_CH_POL_BIT 1
`define SACC_CH_MODE_LSB 2
`define SACC_CH_LEVEL_LSB 4
`define SACC_CH_SREF_BIT 6

// ------------------------------------------------------------
// encodings and reset values
// ------------------------------------------------------------
`define SACC_COUNT_FOUR 2'h0
`define SACC_COUNT_THREE 2'h1
`define SACC_COUNT_TWO 2'h2
`define SACC_MODE_PIXEL 2'h0
`define SACC_MODE_LINE 2'h1
`define SACC_MODE_UNCL_INT 2'h2
`define SACC_MODE_UNCL_EXT 2'h3
`define SACC_LEVEL_FIXED 2'h0
`define SACC_LEVEL_DAC 2'h1
`define SACC_LEVEL_PIN 2'h2
`define SACC_DAC_RESET 2'h0
`define SACC_CHCFG_RESET 32'h0000_0000
`define SACC_WIN_RESET 16'h0000
`define SACC_CLPEND_RESET 8'h01

`endif

/* inc/sacc_pkg.sv */
package sacc_pkg;

    typedef logic [3:0] sacc_chan_t;

    typedef struct packed {
        logic prevStrobe;
        logic [15:0] pixCount;
        logic window;
    } sacc_win_state_t;

    typedef struct packed {
        logic prevRef;
        logic [7:0] widthCount;
        logic [7:0] lastWidth;
        logic [7:0] clampCount;
        logic clampOn;
    } sacc_clp_state_t;

    typedef struct packed {
        logic [1:0] countSel;
        logic [1:0] dacSel;
        logic manualEnd;
        logic winEnable;
        logic [31:0] chanCfg;
        logic [15:0] winStart;
        logic [15:0] winEnd;
        logic [7:0] clampEnd;
        logic [31:0] readData;
        logic [1:0] refPinSync;
        sacc_chan_t active;
        sacc_chan_t cds;
        sacc_chan_t polarity;
        sacc_chan_t refPulse;
        sacc_chan_t dataPulse;
        sacc_chan_t clampSwitch;
        sacc_chan_t intRef;
        sacc_chan_t gndRef;
        sacc_chan_t cfgError;
        logic [7:0] level;
        logic refOe;
    } sacc_top_state_t;

endpackage

/* hw/sacc_window.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sacc_defines.svh"

module sacc_window (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // line timing
    input wire logic lineStrobe,
    // settings
    input wire logic enable,
    input wire logic [15:0] startCount,
    input wire logic [15:0] endCount,
    // window
    output logic window
);
    import sacc_pkg::*;

    sacc_win_state_t state;
    sacc_win_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.prevStrobe = lineStrobe;
        // count restarts on the strobe falling edge; saturates on long lines
        if (state.prevStrobe && !lineStrobe) begin
            next_state.pixCount = 16'h0000;
        end else if (state.pixCount != 16'hffff) begin
            next_state.pixCount = state.pixCount + 16'h0001;
        end
        next_state.window = !enable ||
            (next_state.pixCount >= startCount && next_state.pixCount < endCount);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '{prevStrobe: 1'b0, pixCount: 16'hffff, window: 1'b1};
        end else begin
            state <= next_state;
        end
    end

    assign window = state.window;
endmodule
`default_nettype wire

/* hw/sacc_clamp_pulse.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sacc_defines.svh"

module sacc_clamp_pulse (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // group reference sample pulse
    input wire logic refPulse,
    // end control
    input wire logic manual,
    input wire logic [7:0] manualEnd,
    // clamp pulse
    output logic clamp
);
    import sacc_pkg::*;

    sacc_clp_state_t state;
    sacc_clp_state_t next_state;
    logic [7:0] endAt;

    always_comb begin
        next_state = state;
        // half of the last measured width; the first pulse after reset uses one cycle
        endAt = manual ? manualEnd : {1'b0, state.lastWidth[7:1]};
        if (endAt == 8'h00) begin
            endAt = 8'h01;
        end
        next_state.prevRef = refPulse;
        if (refPulse) begin
            next_state.widthCount = state.prevRef ? state.widthCount + 8'h01 : 8'h01;
        end else if (state.prevRef) begin
            next_state.lastWidth = state.widthCount;
        end
        if (refPulse && !state.prevRef) begin
            next_state.clampOn = 1'b1;
            next_state.clampCount = 8'h01;
        end else if (state.clampOn) begin
            if (state.clampCount >= endAt) begin
                next_state.clampOn = 1'b0;
            end else begin
                next_state.clampCount = state.clampCount + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign clamp = state.clampOn;
endmodule
`default_nettype wire

/* hw/sacc_top.sv */
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sacc_defines.svh"

module sacc_top (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regReadData,
    // timing from the pulse generator
    input wire logic lineStrobe,
    input wire logic [1:0] groupRefPulse,
    input wire logic [1:0] groupDataPulse,
    // per-channel sampler controls
    output sacc_pkg::sacc_chan_t chanActive,
    output sacc_pkg::sacc_chan_t chanCds,
    output sacc_pkg::sacc_chan_t chanPolarity,
    output sacc_pkg::sacc_chan_t refSamplePulse,
    output sacc_pkg::sacc_chan_t dataSamplePulse,
    output sacc_pkg::sacc_chan_t clampSwitch,
    output sacc_pkg::sacc_chan_t useInternalRef,
    output sacc_pkg::sacc_chan_t useGroundPin,
    output logic [7:0] clampLevelSelect,
    // clamp timing
    output logic [1:0] clampPulse,
    output logic dummyWindow,
    // reference DAC and reference pin
    output logic [1:0] refDacLevel,
    input wire logic refPinIn,
    output logic refPinOut,
    output logic refPinOe
);
    import sacc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sacc_top_state_t state;
    sacc_top_state_t next_state;
    logic [1:0] groupClamp;
    logic window;
    logic [1:0] groupActive;
    sacc_chan_t shMode;
    sacc_chan_t lineMode;
    logic [3:0][1:0] chanMode;
    logic [3:0][1:0] chanLevel;
    logic anyDac;
    logic anyPin;

    // ------------------------------------------------------------
    // clamp window and pixel clamp pulses
    // ------------------------------------------------------------
    sacc_window winGen (
        .clk(clk),
        .arst_n(arst_n),
        .lineStrobe(lineStrobe),
        .enable(state.winEnable),
        .startCount(state.winStart),
        .endCount(state.winEnd),
        .window(window)
    );

    // a group stays idle when neither of its inputs is active
    assign groupActive[0] = state.active[0] | state.active[1];
    assign groupActive[1] = state.active[2] | state.active[3];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : grp
            sacc_clamp_pulse clampGen (
                .clk(clk),
                .arst_n(arst_n),
                .refPulse(groupRefPulse[g] & groupActive[g]),
                .manual(state.manualEnd),
                .manualEnd(state.clampEnd),
                .clamp(groupClamp[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // per-channel field decode
    // ------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : chn
            assign shMode[c] = state.chanCfg[8*c + `SACC_CH_SH_BIT];
            assign chanMode[c] = state.chanCfg[8*c + `SACC_CH_MODE_LSB +: 2];
            assign chanLevel[c] = state.chanCfg[8*c + `SACC_CH_LEVEL_LSB +: 2];
            assign lineMode[c] = chanMode[c] == `SACC_MODE_LINE;
        end
    endgenerate

    always_comb begin
        anyDac = 1'b0;
        anyPin = 1'b0;
        for (int i = 0; i < 4; i++) begin
            anyDac = anyDac | (state.active[i] & (chanLevel[i] == `SACC_LEVEL_DAC));
            anyPin = anyPin | (state.active[i] & (chanLevel[i] == `SACC_LEVEL_PIN));
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.refPinSync = {state.refPinSync[0], refPinIn};

        // register writes land on the next edge and hold until rewritten
        if (regWrite) begin
            unique case (regAddr)
                `SACC_OFS_CTRL: begin
                    next_state.countSel = regWriteData[`SACC_CTRL_COUNT_LSB +: 2];
                    next_state.dacSel = regWriteData[`SACC_CTRL_DAC_LSB +: 2];
                    next_state.manualEnd = regWriteData[`SACC_CTRL_MANUAL_BIT];
                    next_state.winEnable = regWriteData[`SACC_CTRL_WINEN_BIT];
                end
                `SACC_OFS_CHCFG: next_state.chanCfg = regWriteData;
                `SACC_OFS_WSTART: next_state.winStart = regWriteData[15:0];
                `SACC_OFS_WEND: next_state.winEnd = regWriteData[15:0];
                `SACC_OFS_CLPEND: next_state.clampEnd = regWriteData[7:0];
                default: begin
                end
            endcase
        end

        // read data stand only in the cycle after the strobe
        next_state.readData = 32'h0000_0000;
        if (regRead) begin
            unique case (regAddr)
                `SACC_OFS_CTRL: begin
                    next_state.readData[`SACC_CTRL_COUNT_LSB +: 2] = state.countSel;
                    next_state.readData[`SACC_CTRL_DAC_LSB +: 2] = state.dacSel;
                    next_state.readData[`SACC_CTRL_MANUAL_BIT] = state.manualEnd;
                    next_state.readData[`SACC_CTRL_WINEN_BIT] = state.winEnable;
                end
                `SACC_OFS_CHCFG: next_state.readData = state.chanCfg;
                `SACC_OFS_WSTART: next_state.readData[15:0] = state.winStart;
                `SACC_OFS_WEND: next_state.readData[15:0] = state.winEnd;
                `SACC_OFS_CLPEND: next_state.readData[7:0] = state.clampEnd;
                `SACC_OFS_STATUS: begin
                    next_state.readData[3:0] = state.active;
                    next_state.readData[7:4] = state.cfgError;
                    next_state.readData[8] = window;
                    next_state.readData[9] = state.refPinSync[1];
                    next_state.readData[11:10] = groupClamp;
                end
                default: begin
                end
            endcase
        end

        // input count decode; the spare code keeps all four inputs
        unique case (state.countSel)
            `SACC_COUNT_THREE: next_state.active = 4'h7;
            `SACC_COUNT_TWO: next_state.active = 4'h5;
            default: next_state.active = 4'hf;
        endcase

        for (int i = 0; i < 4; i++) begin
            next_state.cds[i] = !shMode[i];
            next_state.polarity[i] = state.chanCfg[8*i + `SACC_CH_POL_BIT];
            next_state.level[2*i +: 2] = chanLevel[i];
            // codes 2 and 3 need single sampling; line clamp needs double sampling
            next_state.cfgError[i] = (lineMode[i] & shMode[i]) |
                (chanMode[i][1] & !shMode[i]);
            // two pulses per pixel in double sampling, only the data pulse otherwise
            next_state.refPulse[i] = state.active[i] & !shMode[i] &
                groupRefPulse[i/2];
            next_state.dataPulse[i] = state.active[i] & groupDataPulse[i/2];
            next_state.clampSwitch[i] = 1'b0;
            if (state.active[i]) begin
                unique case (chanMode[i])
                    `SACC_MODE_PIXEL: next_state.clampSwitch[i] = groupClamp[i/2];
                    `SACC_MODE_LINE: next_state.clampSwitch[i] = !shMode[i] &
                        groupRefPulse[i/2] & window;
                    default: next_state.clampSwitch[i] = 1'b0;
                endcase
            end
            next_state.intRef[i] = state.active[i] & shMode[i] &
                ((chanMode[i] == `SACC_MODE_UNCL_INT) |
                state.chanCfg[8*i + `SACC_CH_SREF_BIT]);
            next_state.gndRef[i] = state.active[i] & shMode[i] & !next_state.intRef[i] &
                (chanMode[i] == `SACC_MODE_UNCL_EXT);
        end

        // an external reference on the pin wins; never fight an outside driver
        next_state.refOe = anyDac & !anyPin;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
            state.dacSel <= `SACC_DAC_RESET;
            state.chanCfg <= `SACC_CHCFG_RESET;
            state.winStart <= `SACC_WIN_RESET;
            state.winEnd <= `SACC_WIN_RESET;
            state.clampEnd <= `SACC_CLPEND_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign regReadData = state.readData;
    assign chanActive = state.active;
    assign chanCds = state.cds;
    assign chanPolarity = state.polarity;
    assign refSamplePulse = state.refPulse;
    assign dataSamplePulse = state.dataPulse;
    assign clampSwitch = state.clampSwitch;
    assign useInternalRef = state.intRef;
    assign useGroundPin = state.gndRef;
    assign clampLevelSelect = state.level;
    assign clampPulse = groupClamp;
    assign dummyWindow = window;
    assign refDacLevel = state.dacSel;
    assign refPinOut = state.refOe;
    assign refPinOe = state.refOe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    count_two_a: assert property (state.countSel == `SACC_COUNT_TWO |=>
        chanActive == 4'h5) else $error("two-input mode active mask wrong");

    standby_quiet_a: assert property (!chanActive[3] |=>
        !refSamplePulse[3] && !dataSamplePulse[3] && !clampSwitch[3])
        else $error("standby channel got a pulse");

    cds_ref_a: assert property (groupRefPulse[0] && state.active[0] && !shMode[0] |=>
        refSamplePulse[0] && chanCds[0]) else $error("double sampling lost reference pulse");

    sh_noref_a: assert property (shMode[1] |=> !refSamplePulse[1])
        else $error("single sample channel got reference pulse");

    sh_data_a: assert property (groupDataPulse[1] && state.active[2] |=>
        dataSamplePulse[2]) else $error("data pulse not passed");

    line_sh_a: assert property (lineMode[0] && shMode[0] |=> !clampSwitch[0])
        else $error("line clamp in single sample mode");

    line_window_a: assert property (lineMode[2] && !window |=> !clampSwitch[2])
        else $error("line clamp outside window");

    pixel_clamp_a: assert property (chanMode[0] == `SACC_MODE_PIXEL && state.active[0] &&
        groupClamp[0] |=> clampSwitch[0]) else $error("pixel clamp not passed");

    window_default_a: assert property (!state.winEnable |=> dummyWindow)
        else $error("window low before programming");

    clamp_start_a: assert property ($rose(groupRefPulse[1]) && groupActive[1] |=>
        clampPulse[1]) else $error("clamp pulse did not start on reference edge");

    clamp_manual_a: assert property ($rose(clampPulse[0]) && state.manualEnd &&
        state.clampEnd == 8'h03 && !$rose(groupRefPulse[0]) ##1
        (state.manualEnd && !$rose(groupRefPulse[0]))[*2] |->
        clampPulse[0] ##1 !clampPulse[0]) else $error("manual clamp end wrong");

    clamp_bound_a: assert property (clampPulse[1] && !groupRefPulse[1] |->
        ##[1:256] !clampPulse[1]) else $error("clamp pulse never ends");

    pin_oe_a: assert property (anyPin |=> !refPinOe)
        else $error("reference pin driven against external reference");

    read_slot_a: assert property (!regRead |=> regReadData == 32'h0000_0000)
        else $error("read data outside read slot");

    count_three_a: assert property (
        state.countSel == `SACC_COUNT_THREE |=> chanActive == 4'h7)
        else $error("three-input mode active mask wrong");

    count_four_a: assert property (
        state.countSel == `SACC_COUNT_FOUR |=> chanActive == 4'hf)
        else $error("four-input mode active mask wrong");

    cds_flag_a: assert property (
        shMode[3] |=> !chanCds[3])
        else $error("single sample channel flagged double sampling");

    polarity_copy_a: assert property (
        state.chanCfg[16 + `SACC_CH_POL_BIT] |=> chanPolarity[2])
        else $error("polarity bit not passed");

    level_dac_a: assert property (
        chanLevel[3] == `SACC_LEVEL_DAC |=> clampLevelSelect[7:6] == `SACC_LEVEL_DAC)
        else $error("clamp level select not passed");

    int_ref_a: assert property (
        state.active[2] && shMode[2] && state.chanCfg[16 + `SACC_CH_SREF_BIT] |=>
        useInternalRef[2]) else $error("internal reference not chosen");

    gnd_pin_a: assert property (
        state.active[1] && shMode[1] && chanMode[1] == `SACC_MODE_UNCL_EXT &&
        !state.chanCfg[8 + `SACC_CH_SREF_BIT] |=> useGroundPin[1])
        else $error("ground reference pin not chosen");

    cfg_error_a: assert property (
        chanMode[3][1] && !shMode[3] |=> state.cfgError[3])
        else $error("unclamped mode in double sampling not flagged");

    unclamp_quiet_a: assert property (
        chanMode[3][1] |=> !clampSwitch[3])
        else $error("unclamped channel got a clamp");

    dac_write_a: assert property (
        regWrite && regAddr == `SACC_OFS_CTRL |=>
        refDacLevel == $past(regWriteData[`SACC_CTRL_DAC_LSB +: 2]))
        else $error("reference DAC level not taken");

    window_start_a: assert property (
        $fell(lineStrobe) && state.winEnable && state.winStart != 16'h0000 |=>
        !dummyWindow) else $error("window open at line start");

    line_clamp_a: assert property (
        lineMode[2] && state.active[2] && !shMode[2] && groupRefPulse[1] && window |=>
        clampSwitch[2]) else $error("line clamp missing inside window");

    group_b_a: assert property (
        chanMode[3] == `SACC_MODE_PIXEL && state.active[3] && groupClamp[1] |=>
        clampSwitch[3]) else $error("group B clamp not passed");

    cover_two_c: cover property (chanActive == 4'h5 && dataSamplePulse[2]);
    cover_line_c: cover property (lineMode[0] && clampSwitch[0]);
    cover_manual_c: cover property (state.manualEnd && $fell(clampPulse[0]));
    cover_window_c: cover property (state.winEnable && $rose(dummyWindow));
    cover_sref_c: cover property (useInternalRef[2] && useGroundPin[1]);
endmodule
`default_nettype wire

/* verification/sacc_sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// line sensor timing: 8-clock pixels, 16-pixel lines
// ------------------------------------------------------------
module sacc_sensor_model (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // sensor timing
    output logic lineStrobe,
    output logic [1:0] refPulse,
    output logic [1:0] dataPulse
);
    logic [6:0] phase;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 7'h00;
            lineStrobe <= 1'b0;
            refPulse <= 2'h0;
            dataPulse <= 2'h0;
        end else begin
            phase <= phase + 7'h01;
            lineStrobe <= (phase == 7'h7f);
            // reference first, data later, gap between so single sampling is safe
            refPulse <= {2{phase[2:0] < 3'h4}};
            dataPulse <= {2{phase[2:0] == 3'h6}};
        end
    end
endmodule

`default_nettype wire

/* verification/sacc_top_test.sv */
`timescale 1ns/1ps
`default_nettype none

module sacc_top_test;
    import sacc_pkg::*;
    logic clk, arst_n, regWrite, regRead, lineStrobe, refPinIn;
    logic [3:0] regAddr;
    logic [31:0] regWriteData, regReadData, rdVal;
    logic [1:0] groupRefPulse, groupDataPulse, clampPulse, refDacLevel;
    sacc_chan_t chanActive, chanCds, chanPolarity, refSamplePulse, dataSamplePulse;
    sacc_chan_t clampSwitch, useInternalRef, useGroundPin, seen;
    logic [7:0] clampLevelSelect;
    logic dummyWindow, refPinOut, refPinOe;
    int errTotal, testsRun, nA, nB, nW, nL;

    sacc_sensor_model i_sacc_sensor_model (.clk(clk), .arst_n(arst_n),
        .lineStrobe(lineStrobe), .refPulse(groupRefPulse), .dataPulse(groupDataPulse));

    sacc_top i_sacc_top (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .lineStrobe(lineStrobe), .groupRefPulse(groupRefPulse),
        .groupDataPulse(groupDataPulse), .chanActive(chanActive), .chanCds(chanCds),
        .chanPolarity(chanPolarity), .refSamplePulse(refSamplePulse),
        .dataSamplePulse(dataSamplePulse), .clampSwitch(clampSwitch),
        .useInternalRef(useInternalRef), .useGroundPin(useGroundPin),
        .clampLevelSelect(clampLevelSelect), .clampPulse(clampPulse),
        .dummyWindow(dummyWindow), .refDacLevel(refDacLevel), .refPinIn(refPinIn),
        .refPinOut(refPinOut), .refPinOe(refPinOe));

    // ------------------------------------------------------------
    // bus and check helpers
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 rdVal = regReadData;
        @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            errTotal++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // counts high cycles of both clamp pulses and the window
    task automatic count_hi(input int n);
        nA = 0;
        nB = 0;
        nW = 0;
        nL = 0;
        seen = 4'h0;
        repeat (n) begin
            @(posedge clk);
            #1 nA += int'(clampPulse[0] === 1'b1);
            nB += int'(clampPulse[1] === 1'b1);
            nW += int'(dummyWindow === 1'b1);
            nL += int'(clampSwitch[2] === 1'b1);
            seen |= refSamplePulse;
        end
    endtask

    task automatic wrapUp();
        if (errTotal == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        repeat (6) @(posedge clk);
        #1 chk(32'(dummyWindow), 32'h1);
        chk(32'(clampPulse), 32'h0);
        wait (arst_n === 1'b1);
        @(posedge clk);
        rd(4'h0);
        chk(rdVal, 32'h0);
        chk(32'(refDacLevel), 32'h0);
    endtask

    task automatic t_count();
        logic [3:0] exp [3] = '{4'hf, 4'h7, 4'h5};
        for (int i = 0; i < 3; i++) begin
            wr(4'h0, 32'(i));
            count_hi(10);
            chk(32'(chanActive), 32'(exp[i]));
            chk(32'(seen), 32'(exp[i]));
        end
        wr(4'h0, 32'h0);
    endtask

    task automatic t_config();
        // ch0/ch2 single sampling, ch1/ch3 double; all inverted, DAC level
        wr(4'h1, 32'h1213_1213);
        repeat (3) @(posedge clk);
        chk(32'(chanCds), 32'ha);
        chk(32'(chanPolarity), 32'hf);
        chk(32'(clampLevelSelect), 32'h55);
        chk(32'(refPinOe), 32'h1);
        chk(32'(refPinOut), 32'h1);
        rd(4'h1);
        chk(rdVal, 32'h1213_1213);
        rd(4'hf);
        chk(rdVal, 32'h0);
        wr(4'h0, 32'h30);
        chk(32'(refDacLevel), 32'h3);
        wr(4'h1, 32'h0841_0d09);
        refPinIn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(4'h5);
        chk(32'(rdVal[9]), 32'h1);
        chk(32'(rdVal[7:4]), 32'h8);
        chk(32'(useInternalRef), 32'h5);
        chk(32'(useGroundPin), 32'h2);
        chk(32'(refPinOe), 32'h0);
    endtask

    task automatic t_window();
        // window over clocks 2 to 4 of the first pixel of each line
        wr(4'h2, 32'h2);
        wr(4'h3, 32'h5);
        wr(4'h0, 32'h200);
        wr(4'h1, 32'h0004_0004);
        repeat (130) @(posedge clk);
        count_hi(128);
        chk(32'(nW), 32'h3);
        chk(32'(nL), 32'h1);
    endtask

    task automatic t_clamp();
        wr(4'h4, 32'h3);
        wr(4'h0, 32'h300);
        repeat (16) @(posedge clk);
        count_hi(8);
        chk(32'(nA), 32'h3);
        chk(32'(nB), 32'h3);
        wr(4'h0, 32'h200);
        repeat (16) @(posedge clk);
        count_hi(8);
        // reference pulse is 4 clocks wide, half of that is 2
        chk(32'(nA), 32'h2);
        chk(32'(nB), 32'h2);
    endtask

    // ------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        arst_n = 1'b0;
        regAddr = 4'h0;
        regWriteData = 32'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
        refPinIn = 1'b0;
        errTotal = 0;
        testsRun = 0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
    end

    initial begin
        t_reset();
        t_count();
        t_config();
        t_window();
        t_clamp();
        wrapUp();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        wrapUp();
    end
endmodule

`default_nettype wire
